// File: hdl/dcs_decim.sv
// Boxcar decimator for phase detector samples
// Assumes one sample per asserted in_valid, ratio of zero acts as one
`timescale 1ns/1ps
`include "dcs_map.svh"
module dcs_decim import dcs_pkg::*; #(
    parameter int RW = 16
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // Samples in
    input wire dcs_err_t in_s,
    input wire logic [RW-1:0] ratio,
    // Decimated sum out
    output dcs_err_t out_q
);
    logic [RW-1:0] cnt_q;
    logic signed [`DCS_PCW_W-1:0] acc_q;
    logic signed [`DCS_PCW_W-1:0] sum;
    logic last;

    assign sum = acc_q + in_s.err;
    assign last = (ratio == '0) || (cnt_q >= ratio - 1'b1);

    // Sum wraps at 32 bits; host divides by the ratio
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            cnt_q <= '0;
            acc_q <= '0;
            out_q <= '0;
        end else if (in_s.valid && last) begin
            cnt_q <= '0;
            acc_q <= '0;
            out_q <= {1'b1, sum};
        end else if (in_s.valid) begin
            cnt_q <= cnt_q + 1'b1;
            acc_q <= sum;
            out_q.valid <= 1'b0;
        end else begin
            out_q.valid <= 1'b0;
        end
    end
endmodule

// File: hdl/dcs_map.svh
// Register offsets, field positions, reset values and timing counts
// Assumes byte addresses on a 32-bit AHB-Lite bus, one word per register
`ifndef DCS_MAP_SVH
`define DCS_MAP_SVH

`define DCS_CTRL 8'h00
`define DCS_DECIM 8'h04
`define DCS_PHERR 8'h08
`define DCS_STATUS 8'h0c
`define DCS_FCW_LO 8'h10
`define DCS_FCW_HI 8'h14
`define DCS_INCDEC 8'h18
`define DCS_STEP 8'h1c
`define DCS_PCW 8'h20
`define DCS_PCW_TIME 8'h24
`define DCS_CH_OFFSET 8'h28
`define DCS_OUT_PHASE 8'h2c
`define DCS_IN_OFFSET 8'h40

`define DCS_CTRL_MODE_LSB 0
`define DCS_CTRL_TIMER_EN 4
`define DCS_CTRL_EXP_HOLD 5
`define DCS_CTRL_PIN_EN 6
`define DCS_INCDEC_DEC_LSB 8
`define DCS_ST_NEW 0
`define DCS_ST_HOLD 1
`define DCS_ST_TIMER 2
`define DCS_ST_REF_LSB 8

`define DCS_DECIM_RST 16'h0001
`define DCS_FCW_W 42
`define DCS_FCW_REG_W 48
`define DCS_PCW_W 32

`define DCS_CLK_PERIOD_NS 100
`define DCS_TIMER_LSB_NS 1000000
`define DCS_MS_CYCLES (`DCS_TIMER_LSB_NS / `DCS_CLK_PERIOD_NS)

`endif

// File: hdl/dcs_ms_timer.sv
// Millisecond countdown that limits how long a phase word acts
// Assumes start is a one-cycle pulse; a zero count never runs
`timescale 1ns/1ps
`include "dcs_map.svh"
module dcs_ms_timer #(
    parameter int MS_CYCLES = `DCS_MS_CYCLES
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // Control
    input wire logic start,
    input wire logic stop,
    input wire logic [15:0] ms_count,
    // Status
    output logic running_q,
    output logic expired_q
);
    localparam int PW = $clog2(MS_CYCLES);
    localparam logic [PW-1:0] PRE_LAST = PW'(MS_CYCLES - 1);
    logic [PW-1:0] pre_q;
    logic [15:0] ms_q;

    always_ff @(posedge mclk) begin
        if (!rstn || stop) begin
            pre_q <= '0;
            ms_q <= '0;
            running_q <= 1'b0;
            expired_q <= 1'b0;
        end else if (start) begin
            pre_q <= '0;
            ms_q <= ms_count;
            running_q <= (ms_count != 16'h0000);
            expired_q <= 1'b0;
        end else if (running_q && pre_q == PRE_LAST) begin
            pre_q <= '0;
            ms_q <= ms_q - 16'h0001;
            running_q <= (ms_q != 16'h0001);
            expired_q <= (ms_q == 16'h0001);
        end else begin
            pre_q <= running_q ? pre_q + 1'b1 : '0;
            expired_q <= 1'b0;
        end
    end
endmodule

// File: hdl/dcs_pkg.sv
// Types shared by the external steering block
// Assumes the map header supplies widths
`include "dcs_map.svh"
package dcs_pkg;
    typedef enum logic [1:0] {
        DCS_CLOSED,
        DCS_EXT_LF,
        DCS_WR_FREQ,
        DCS_WR_PHASE
    } dcs_mode_t;

    // Phase error sample, one update tick
    typedef struct packed {
        logic valid;
        logic signed [`DCS_PCW_W-1:0] err;
    } dcs_err_t;
endpackage

// File: hdl/dcs_top.sv
// External steering of one channel's oscillator via AHB-Lite registers
// Assumes pd_s and dlf_word come from the channel, pins are synchronous
//
// Added by the designer: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ps
`include "dcs_map.svh"
module dcs_top import dcs_pkg::*; #(
    parameter int NUM_IN = 8,
    parameter int OSC_IDX = 0,
    parameter int DECIM_W = 16,
    parameter int MS_CYCLES = `DCS_MS_CYCLES
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Channel side
    input wire dcs_err_t pd_s,
    input wire logic [`DCS_FCW_W-1:0] dlf_word,
    input wire logic [$clog2(NUM_IN)-1:0] act_ref,
    input wire logic inc_pin,
    input wire logic dec_pin,
    // Steering out
    output logic [`DCS_FCW_W-1:0] fod_steer_q,
    output dcs_err_t dlf_in_q,
    output logic holdover_q,
    output logic [31:0] out_phase_q,
    output logic phase_jump_q
);
    localparam int RIW = $clog2(NUM_IN);
    default disable iff (!rstn);
    // Bus state
    logic wr_q, acc, wr_en, rd_acc;
    logic [7:0] addr_q;
    logic [31:0] rd_d;
    // Registers
    dcs_mode_t mode_q;
    logic timer_en_q, exp_hold_q, pin_en_q, new_q;
    logic [DECIM_W-1:0] decim_q;
    logic [31:0] pherr_q, fcw_lo_q, step_q;
    logic signed [`DCS_FCW_W-1:0] fcw_q;
    logic signed [`DCS_PCW_W-1:0] pcw_q;
    logic [15:0] pcw_time_q;
    logic signed [31:0] ch_off_q, comb_off_q;
    logic signed [31:0] in_off_q [NUM_IN];
    logic inc_pin_q, dec_pin_q;
    // Events
    dcs_err_t dec_s, dec_o;
    logic wr_fcw_hi, wr_pcw, inc_ev, dec_ev;
    logic tmr_run, tmr_exp, freq_mode;
    logic [`DCS_FCW_W-1:0] step_x;

    assign acc = hsel && hready && htrans[1];
    assign rd_acc = acc && !hwrite;
    assign wr_en = wr_q;
    assign wr_fcw_hi = wr_en && addr_q == `DCS_FCW_HI;
    assign wr_pcw = wr_en && addr_q == `DCS_PCW;
    assign freq_mode = mode_q == DCS_EXT_LF || mode_q == DCS_WR_FREQ;
    assign step_x = {{(`DCS_FCW_W-32){1'b0}}, step_q};
    // Zero wait states, always OKAY; same value in and out of reset
    always_ff @(posedge mclk) begin
        hreadyout <= 1'b1;
        hresp <= 1'b0;
    end
    // Address phase capture; only whole-word writes are accepted
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            wr_q <= 1'b0;
            addr_q <= 8'h00;
        end else begin
            wr_q <= acc && hwrite && hsize == 3'b010;
            addr_q <= haddr[7:0];
        end
    end

    // Read mux, unmapped reads as zero
    always_comb begin
        rd_d = 32'h0000_0000;
        if (haddr[7:0] == `DCS_CTRL) begin
            rd_d[`DCS_CTRL_MODE_LSB +: 2] = mode_q;
            rd_d[`DCS_CTRL_TIMER_EN] = timer_en_q;
            rd_d[`DCS_CTRL_EXP_HOLD] = exp_hold_q;
            rd_d[`DCS_CTRL_PIN_EN] = pin_en_q;
        end else if (haddr[7:0] == `DCS_DECIM) begin
            rd_d[DECIM_W-1:0] = decim_q;
        end else if (haddr[7:0] == `DCS_PHERR) begin
            rd_d = pherr_q;
        end else if (haddr[7:0] == `DCS_STATUS) begin
            rd_d[`DCS_ST_NEW] = new_q;
            rd_d[`DCS_ST_HOLD] = holdover_q;
            rd_d[`DCS_ST_TIMER] = tmr_run;
            rd_d[`DCS_ST_REF_LSB +: RIW] = act_ref;
        end else if (haddr[7:0] == `DCS_FCW_LO) begin
            rd_d = fcw_q[31:0];
        end else if (haddr[7:0] == `DCS_FCW_HI) begin
            rd_d[15:0] = {{6{fcw_q[`DCS_FCW_W-1]}}, fcw_q[41:32]};
        end else if (haddr[7:0] == `DCS_STEP) begin
            rd_d = step_q;
        end else if (haddr[7:0] == `DCS_PCW) begin
            rd_d = pcw_q;
        end else if (haddr[7:0] == `DCS_PCW_TIME) begin
            rd_d[15:0] = pcw_time_q;
        end else if (haddr[7:0] == `DCS_CH_OFFSET) begin
            rd_d = ch_off_q;
        end else if (haddr[7:0] == `DCS_OUT_PHASE) begin
            rd_d = out_phase_q;
        end else if (haddr[7:0] >= `DCS_IN_OFFSET &&
                     haddr[7:0] < `DCS_IN_OFFSET + 8'(4 * NUM_IN)) begin
            rd_d = in_off_q[RIW'((haddr[7:0] - `DCS_IN_OFFSET) >> 2)];
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            hrdata <= 32'h0000_0000;
        end else if (rd_acc) begin
            hrdata <= rd_d;
        end
    end

    // Control fields
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            mode_q <= DCS_CLOSED;
            timer_en_q <= 1'b0;
            exp_hold_q <= 1'b0;
            pin_en_q <= 1'b0;
            decim_q <= DECIM_W'(`DCS_DECIM_RST);
            step_q <= 32'h0000_0000;
            pcw_time_q <= 16'h0000;
            ch_off_q <= 32'sh0000_0000;
        end else if (wr_en) begin
            if (addr_q == `DCS_CTRL) begin
                mode_q <= dcs_mode_t'(hwdata[`DCS_CTRL_MODE_LSB +: 2]);
                timer_en_q <= hwdata[`DCS_CTRL_TIMER_EN];
                exp_hold_q <= hwdata[`DCS_CTRL_EXP_HOLD];
                pin_en_q <= hwdata[`DCS_CTRL_PIN_EN];
            end else if (addr_q == `DCS_DECIM) begin
                decim_q <= hwdata[DECIM_W-1:0];
            end else if (addr_q == `DCS_STEP) begin
                step_q <= hwdata;
            end else if (addr_q == `DCS_PCW_TIME) begin
                pcw_time_q <= hwdata[15:0];
            end else if (addr_q == `DCS_CH_OFFSET) begin
                ch_off_q <= hwdata;
            end
        end
    end
    // Per-input offsets
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            for (int i = 0; i < NUM_IN; i++) begin
                in_off_q[i] <= 32'sh0000_0000;
            end
        end else if (wr_en && addr_q >= `DCS_IN_OFFSET &&
                     addr_q < `DCS_IN_OFFSET + 8'(4 * NUM_IN)) begin
            in_off_q[RIW'((addr_q - `DCS_IN_OFFSET) >> 2)] <= hwdata;
        end
    end
    // Decimated error export in external-filter mode
    assign dec_s = {pd_s.valid && mode_q == DCS_EXT_LF, pd_s.err};

    dcs_decim #(
        .RW(DECIM_W)
    ) u_decim (
        .mclk(mclk),
        .rstn(rstn),
        .in_s(dec_s),
        .ratio(decim_q),
        .out_q(dec_o)
    );
    // Fresh sample flag; a new sample beats the read that clears it
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            pherr_q <= 32'h0000_0000;
            new_q <= 1'b0;
        end else if (dec_o.valid) begin
            pherr_q <= dec_o.err;
            new_q <= 1'b1;
        end else if (rd_acc && haddr[7:0] == `DCS_PHERR) begin
            new_q <= 1'b0;
        end
    end
    // Step triggers from register and pins
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            inc_pin_q <= 1'b0;
            dec_pin_q <= 1'b0;
        end else begin
            inc_pin_q <= inc_pin;
            dec_pin_q <= dec_pin;
        end
    end

    always_comb begin
        inc_ev = pin_en_q && inc_pin && !inc_pin_q;
        dec_ev = pin_en_q && dec_pin && !dec_pin_q;
        if (wr_en && addr_q == `DCS_INCDEC) begin
            inc_ev = inc_ev || hwdata[OSC_IDX];
            dec_ev = dec_ev || hwdata[`DCS_INCDEC_DEC_LSB + OSC_IDX];
        end
    end
    // Low half is staged; the high-half write commits the whole word
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            fcw_lo_q <= 32'h0000_0000;
        end else if (wr_en && addr_q == `DCS_FCW_LO) begin
            fcw_lo_q <= hwdata;
        end
    end
    // Upper six register bits are only sign copies and are dropped
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            fcw_q <= '0;
        end else if (wr_fcw_hi) begin
            fcw_q <= {hwdata[9:0], fcw_lo_q};
        end else if (inc_ev && !dec_ev) begin
            fcw_q <= fcw_q + step_x;
        end else if (dec_ev && !inc_ev) begin
            fcw_q <= fcw_q - step_x;
        end
    end
    // Divider steering; a held word keeps the frequency steady
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            fod_steer_q <= '0;
        end else if (freq_mode) begin
            fod_steer_q <= fcw_q;
        end else if (!holdover_q) begin
            fod_steer_q <= dlf_word;
        end
    end
    // Phase word, limited in time by the millisecond timer
    dcs_ms_timer #(
        .MS_CYCLES(MS_CYCLES)
    ) u_timer (
        .mclk(mclk),
        .rstn(rstn),
        .start(wr_pcw && timer_en_q),
        .stop(!timer_en_q),
        .ms_count(pcw_time_q),
        .running_q(tmr_run),
        .expired_q(tmr_exp)
    );

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            pcw_q <= '0;
        end else if (wr_pcw) begin
            pcw_q <= hwdata;
        end else if (tmr_exp && !exp_hold_q) begin
            pcw_q <= '0;
        end
    end
    // Expiry can park the channel; a new word or mode write releases it
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            holdover_q <= 1'b0;
        end else if (tmr_exp && exp_hold_q) begin
            holdover_q <= 1'b1;
        end else if (wr_pcw || (wr_en && addr_q == `DCS_CTRL)) begin
            holdover_q <= 1'b0;
        end
    end
    // Follows the active input each cycle, so a switch takes effect next
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            comb_off_q <= 32'sh0000_0000;
        end else begin
            comb_off_q <= ch_off_q + in_off_q[act_ref];
        end
    end
    // Loop filter input; bypassed in frequency modes, and in holdover in write-phase mode only
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            dlf_in_q <= '0;
        end else if (pd_s.valid && !holdover_q &&
                     mode_q == DCS_WR_PHASE) begin
            dlf_in_q <= {1'b1, pcw_q};
        end else if (pd_s.valid && mode_q == DCS_CLOSED) begin
            dlf_in_q <= {1'b1, pd_s.err + comb_off_q};
        end else begin
            dlf_in_q.valid <= 1'b0;
        end
    end
    // Snap alignment of the output phase
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            out_phase_q <= 32'h0000_0000;
            phase_jump_q <= 1'b0;
        end else begin
            phase_jump_q <= wr_en && addr_q == `DCS_OUT_PHASE;
            if (wr_en && addr_q == `DCS_OUT_PHASE) begin
                out_phase_q <= hwdata;
            end
        end
    end
    a_fcw_lo_stage: assert property (@(posedge mclk)
        wr_en && addr_q == `DCS_FCW_LO && !inc_ev && !dec_ev
        |=> fcw_q == $past(fcw_q))
        else $error("frequency word moved on low-half write");
    a_fcw_commit: assert property (@(posedge mclk)
        wr_fcw_hi && mode_q == DCS_WR_FREQ
        |=> ##1 fod_steer_q == {$past(hwdata[9:0], 2), $past(fcw_lo_q, 2)})
        else $error("committed word not steering divider");
    a_step_inc: assert property (@(posedge mclk)
        inc_ev && !dec_ev && !wr_fcw_hi
        |=> fcw_q == $past(fcw_q) + $past(step_x))
        else $error("increment not applied");
    a_bypass_dlf: assert property (@(posedge mclk)
        freq_mode
        |=> !dlf_in_q.valid)
        else $error("loop filter fed in frequency mode");
    a_comb_offset: assert property (@(posedge mclk)
        $stable(act_ref) && $stable(ch_off_q) ##1 $changed(act_ref)
        |=> ##1 comb_off_q == ch_off_q + in_off_q[$past(act_ref, 1)])
        else $error("offset not recomputed on switch");
    a_err_sum: assert property (@(posedge mclk)
        pd_s.valid && mode_q == DCS_CLOSED
        |=> dlf_in_q.valid &&
            dlf_in_q.err == $past(pd_s.err) + $past(comb_off_q))
        else $error("offset not summed into error");
    a_pcw_expire: assert property (@(posedge mclk)
        tmr_exp && !exp_hold_q && !wr_pcw
        |=> pcw_q == 0 ##1 (pcw_q == 0 || $past(wr_pcw)))
        else $error("phase word not zeroed on expiry");
    a_phase_snap: assert property (@(posedge mclk)
        wr_en && addr_q == `DCS_OUT_PHASE
        |=> phase_jump_q && out_phase_q == $past(hwdata) ##1 !phase_jump_q)
        else $error("phase snap not one pulse");
    a_decim_flag: assert property (@(posedge mclk)
        dec_o.valid
        |=> new_q && pherr_q == $past(dec_o.err))
        else $error("decimated sample not exported");
endmodule

// File: tb/dcs_host_model.sv
// Host processor model: register bus master and servo word arithmetic
// Assumes hready is the slave's hreadyout looped back
`timescale 1ns/1ps
`include "dcs_map.svh"
module dcs_host_model (
    // Clock
    input wire logic mclk,
    // AHB-Lite master
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata
);
    initial begin
        hsel = 1'b1;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0;
    end

    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] q);
        htrans <= 2'b10;
        haddr <= {24'h0, a};
        hwrite <= w;
        hsize <= 3'b010;
        do @(posedge mclk); while (hready !== 1'b1);
        htrans <= 2'b00;
        hwdata <= w ? d : ~hwdata;
        do @(posedge mclk); while (hready !== 1'b1);
        q = hrdata;
        // Released data lines must not keep showing the last word
        hwdata <= ~hwdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        xfer(1'b0, a, 32'h0, q);
    endtask

    // Low half first, high half commits
    task automatic wr_fcw(input logic [41:0] w);
        logic [47:0] x;
        x = {{6{w[41]}}, w};
        wr(`DCS_FCW_LO, x[31:0]);
        wr(`DCS_FCW_HI, {16'h0, x[47:32]});
    endtask

    function automatic logic [41:0] ppm_to_fcw(input real ppm);
        real r;
        r = (1.0 - 1.0 / (1.0 + ppm / 1.0e6)) * (2.0 ** 53);
        return 42'(longint'(r));
    endfunction
endmodule

// File: tb/testbench.sv
// Self-checking bench for the external steering block
// Assumes the host model masters the register bus
`timescale 1ns/1ps
`include "dcs_map.svh"
module testbench import dcs_pkg::*;;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic hsel, hwrite, hreadyout, hresp, inc_pin, dec_pin, phase_jump_q;
    logic holdover_q;
    logic [31:0] haddr, hwdata, hrdata, out_phase_q, q;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [41:0] dlf_word, fod_steer_q;
    logic [2:0] act_ref;
    dcs_err_t pd_s, dlf_in_q;
    int num_errors = 0;
    int cmp_count = 0;

    always #50 mclk = ~mclk;

    dcs_host_model i_host (.mclk(mclk), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata));

    dcs_top #(.MS_CYCLES(4)) i_dut (.mclk(mclk), .rstn(rstn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .pd_s(pd_s), .dlf_word(dlf_word),
        .act_ref(act_ref), .inc_pin(inc_pin), .dec_pin(dec_pin),
        .fod_steer_q(fod_steer_q), .dlf_in_q(dlf_in_q),
        .holdover_q(holdover_q), .out_phase_q(out_phase_q),
        .phase_jump_q(phase_jump_q));

    task automatic chk(input string nm, input logic [47:0] got, exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic settle();
        repeat (2) @(posedge mclk);
        #1;
    endtask

    // One-cycle detector update, then the filter input is visible
    task automatic tick(input logic [31:0] e);
        @(posedge mclk);
        pd_s <= {1'b1, e};
        @(posedge mclk);
        pd_s <= '0;
        #1;
    endtask

    task automatic t_reset();
        chk("hreadyout", hreadyout, 1'b1);
        chk("hresp", hresp, 1'b0);
        i_host.rd(`DCS_CTRL, q);
        chk("ctrl", q, 32'h0);
        i_host.rd(`DCS_DECIM, q);
        chk("decim", q, 32'h1);
        i_host.rd(8'h30, q);
        chk("unmapped", q, 32'h0);
        chk("steer", fod_steer_q, 42'h0);
        $display("reset test done");
    endtask

    task automatic t_wfreq();
        logic [41:0] w [3];
        w = '{i_host.ppm_to_fcw(-2.5), i_host.ppm_to_fcw(1.0),
              42'h1ff_ffff_ffff};
        i_host.wr(`DCS_CTRL, 32'h2);
        i_host.wr(`DCS_FCW_LO, w[0][31:0]);
        settle();
        chk("lo only", fod_steer_q, 42'h0);
        foreach (w[i]) begin
            i_host.wr_fcw(w[i]);
            settle();
            chk("steer", fod_steer_q, w[i]);
            chk("sign", fod_steer_q[41], i == 0);
            repeat (30) @(posedge mclk);
            chk("held", fod_steer_q, w[i]);
        end
        i_host.rd(`DCS_FCW_LO, q);
        chk("fcw lo", q, w[2][31:0]);
        $display("write frequency test done");
    endtask

    task automatic t_incdec();
        logic [31:0] cmd [4] = '{32'h100, 32'h1, 32'h101, 32'h2};
        logic [41:0] ex [4] = '{42'h3ff_ffff_fffb, 42'h0, 42'h0, 42'h0};
        i_host.wr(`DCS_CTRL, 32'h42);
        i_host.wr_fcw(42'h0);
        i_host.wr(`DCS_STEP, 32'h5);
        foreach (cmd[i]) begin
            i_host.wr(`DCS_INCDEC, cmd[i]);
            settle();
            chk("incdec", fod_steer_q, ex[i]);
        end
        for (int i = 0; i < 2; i++) begin
            if (i == 0) inc_pin <= 1'b1;
            else dec_pin <= 1'b1;
            // Held high for several cycles: only the rising edge counts
            repeat (3) @(posedge mclk);
            inc_pin <= 1'b0;
            dec_pin <= 1'b0;
            settle();
            chk("pin", fod_steer_q, i == 0 ? 42'd5 : 42'd0);
        end
        $display("increment decrement test done");
    endtask

    task automatic t_extlf();
        i_host.wr(`DCS_CTRL, 32'h1);
        i_host.wr(`DCS_DECIM, 32'h3);
        tick(32'ha);
        tick(32'h14);
        tick(32'hffff_fffb);
        settle();
        i_host.rd(`DCS_STATUS, q);
        chk("new set", q[0], 1'b1);
        i_host.rd(`DCS_PHERR, q);
        chk("pherr", q, 32'h19);
        i_host.rd(`DCS_STATUS, q);
        chk("new clr", q[0], 1'b0);
        $display("external filter test done");
    endtask

    task automatic t_closed();
        i_host.wr(`DCS_CTRL, 32'h0);
        i_host.wr(`DCS_CH_OFFSET, 32'h64);
        i_host.wr(`DCS_IN_OFFSET + 8'h08, 32'h7);
        i_host.wr(`DCS_IN_OFFSET + 8'h14, 32'hffff_fffd);
        dlf_word <= 42'h155;
        act_ref <= 3'd2;
        settle();
        tick(32'h32);
        chk("valid", dlf_in_q.valid, 1'b1);
        chk("offset", {dlf_in_q.err}, 32'h9d);
        chk("follow", fod_steer_q, 42'h155);
        act_ref <= 3'd5;
        settle();
        tick(32'h32);
        chk("switch", {dlf_in_q.err}, 32'h93);
        $display("closed loop test done");
    endtask

    task automatic t_phase();
        i_host.wr(`DCS_PCW_TIME, 32'h3);
        i_host.wr(`DCS_CTRL, 32'h13);
        i_host.wr(`DCS_PCW, 32'hffff_ffd8);
        tick(32'h9);
        chk("pcw", {dlf_in_q.err}, 32'hffff_ffd8);
        repeat (20) @(posedge mclk);
        tick(32'h9);
        chk("zeroed", {dlf_in_q.err}, 32'h0);
        i_host.wr(`DCS_CTRL, 32'h33);
        i_host.wr(`DCS_PCW, 32'hffff_ffd8);
        repeat (6) @(posedge mclk);
        #1;
        chk("early", holdover_q, 1'b0);
        repeat (12) @(posedge mclk);
        #1;
        chk("holdover", holdover_q, 1'b1);
        i_host.wr(`DCS_CTRL, 32'h3);
        i_host.wr(`DCS_PCW, 32'h0);
        settle();
        chk("resume", holdover_q, 1'b0);
        $display("write phase test done");
    endtask

    task automatic t_snap();
        logic seen;
        seen = 1'b0;
        i_host.wr(`DCS_OUT_PHASE, 32'h0000_1234);
        for (int i = 0; i < 4 && !seen; i++) begin
            #1;
            if (phase_jump_q === 1'b1) seen = 1'b1;
            else @(posedge mclk);
        end
        chk("jump", seen, 1'b1);
        chk("phase", out_phase_q, 32'h0000_1234);
        $display("phase snap test done");
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial begin
        pd_s = '0;
        dlf_word = 42'h0;
        act_ref = 3'd0;
        inc_pin = 1'b0;
        dec_pin = 1'b0;
        repeat (6) @(posedge mclk);
        rstn <= 1'b1;
        @(posedge mclk);
        #1;
        t_reset();
        t_wfreq();
        t_incdec();
        t_extlf();
        t_closed();
        t_phase();
        t_snap();
        end_of_test();
    end

    // Whole run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge mclk);
        num_errors++;
        end_of_test();
    end
endmodule
